// ---- hdl/input_cond_consts.svh ----
// Constants for the input conditioning block
`ifndef INPUT_COND_CONSTS_SVH
`define INPUT_COND_CONSTS_SVH

// Clock and time base
`define CLK_KHZ           25000
`define TICK_US           100
`define TICK_CYCLES       ((`CLK_KHZ * `TICK_US) / 1000)
`define TICKS_PER_MS      (1000 / `TICK_US)
`define REFRESH_GAP_US    1300

// Word 001 filter lengths in ticks, one per time constant setting, and the word 000 extra tick
`define W1_TICKS_0        11'h002
`define W1_TICKS_1        11'h00A
`define W1_TICKS_2        11'h014
`define W1_TICKS_3        11'h028
`define W1_TICKS_4        11'h04B
`define W1_TICKS_5        11'h096
`define W1_TICKS_6        11'h12C
`define W1_TICKS_7        11'h258
`define W0_EXTRA_TICKS    11'h001

// Terminal layout
`define IN_W              12
`define OUT_W             16
`define FAST_BIT0         3
`define KNOB_MAX          8'hC8

// Register byte addresses and knob word indices
`define ADR_IN_W0         12'h000
`define ADR_IN_W1         12'h004
`define ADR_OUT_W0        12'h008
`define ADR_OUT_W1        12'h00C
`define ADR_FILT          12'h010
`define ADR_MODE          12'h014
`define ADR_SETV0         12'h020
`define ADR_SETV1         12'h024
`define ADR_SETV2         12'h028
`define ADR_SETV3         12'h02C
`define ADR_IRQ           12'h030
`define ADR_STAT          12'h034
`define IDX_KNOB0         10'h0FA
`define IDX_KNOB1         10'h0FB

// Reset values
`define FILT_SEL_RST      3'h3
`define MODE_RST          8'h00
`define SETV_RST          16'h0000

`endif

// ---- hdl/input_cond_pkg.sv ----
// Types shared by the input conditioning block
package input_cond_pkg;

   typedef enum logic [1:0] {
      FAST_OFF,
      FAST_DIRECT,
      FAST_COUNT,
      FAST_CATCH
   } fast_mode_e;

   typedef logic [15:0] word_t;

endpackage

// ---- hdl/fast_line_if.sv ----
// Signals between the core and one fast input line
`timescale 1ns/1ps
interface fast_line_if;
   import input_cond_pkg::*;

   logic       pin;
   fast_mode_e mode;
   word_t      set_value;
   logic       irq_ack;
   logic       clear_catch;
   logic       irq;
   logic       caught;

   modport core (output pin, output mode, output set_value, output irq_ack,
                 output clear_catch, input irq, input caught);
   modport line (input pin, input mode, input set_value, input irq_ack,
                 input clear_catch, output irq, output caught);
endinterface

// ---- hdl/fast_line.sv ----
// One fast input line: direct interrupt, pulse counting or pulse catch
`timescale 1ns/1ps
module fast_line (
   // Clock and reset
   input wire logic     core_clk,
   input wire logic     reset,
   // Core side
   fast_line_if.line    lnk
);
   import input_cond_pkg::*;

   logic  pin_prev_reg;
   logic  rise;
   word_t count_reg;
   logic  count_hit;
   logic  irq_reg;
   logic  caught_reg;

   assign rise = lnk.pin & ~pin_prev_reg;
   // count reaches set value (zero fires on every pulse)
   assign count_hit = (lnk.mode == FAST_COUNT) && rise
                      && ((count_reg + 16'h0001) >= lnk.set_value);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pin_prev_reg <= 1'b0;
      end else begin
         pin_prev_reg <= lnk.pin;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || lnk.mode != FAST_COUNT) begin
         count_reg <= 16'h0000;
      end else if (count_hit) begin
         count_reg <= 16'h0000;
      end else if (rise) begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   // direct edge raises interrupt at once; new event beats the ack
   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_reg <= 1'b0;
      end else if ((lnk.mode == FAST_DIRECT && rise) || count_hit) begin
         irq_reg <= 1'b1;
      end else if (lnk.irq_ack) begin
         irq_reg <= 1'b0;
      end
   end

   // latch short pulses until the program reads them
   always_ff @(posedge core_clk) begin
      if (reset) begin
         caught_reg <= 1'b0;
      end else if (lnk.mode == FAST_CATCH && rise) begin
         caught_reg <= 1'b1;
      end else if (lnk.clear_catch) begin
         caught_reg <= 1'b0;
      end
   end

   assign lnk.irq    = irq_reg;
   assign lnk.caught = caught_reg;
endmodule

// ---- hdl/input_conditioning.sv ----
// Input conditioning core: filtering, word mapping, knobs and fast lines
`timescale 1ns/1ps
`include "input_cond_consts.svh"

module input_conditioning #(
   parameter int FAST_LINES         = 4,
   parameter int REFRESH_GAP_CYCLES = (`CLK_KHZ * `REFRESH_GAP_US) / 1000
) (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  reset,
   // Wishbone slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [11:0]           wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output      logic [31:0]           wb_dat_o,
   output      logic                  wb_ack_o,
   // Field terminals
   input  wire logic [2*`IN_W-1:0]    in_pins,
   input  wire logic [7:0]            knob_zero_pos,
   input  wire logic [7:0]            knob_one_pos,
   output      logic [2*`OUT_W-1:0]   out_pins,
   // Scan engine
   output      logic [FAST_LINES-1:0] irq_req,
   input  wire logic [FAST_LINES-1:0] irq_ack,
   input  wire logic                  immediate_io_refresh,
   output      logic                  fatal_refresh_error
);
   import input_cond_pkg::*;

   localparam int NIN = 2 * `IN_W;

   // Synchronisers
   logic [NIN-1:0]  in_meta_reg;
   logic [NIN-1:0]  in_sync_reg;
   logic [15:0]     knob_meta_reg;
   logic [15:0]     knob_sync_reg;

   // Time base and filter
   logic [11:0]     tick_cnt_reg;
   logic            tick;
   logic [10:0]     flt_cnt_reg [NIN];
   logic [NIN-1:0]  in_filt_reg;

   // Software registers
   logic [`OUT_W-1:0] out_w0_reg;
   logic [`OUT_W-1:0] out_w1_reg;
   logic [2:0]        filt_sel_reg;
   logic [7:0]        mode_reg;
   word_t             set_val_reg [4];
   word_t             knob_zero_reg;
   word_t             knob_one_reg;

   // Bus
   logic            req;
   logic            wr;
   logic            rd;
   logic [31:0]     rd_data;
   logic [31:0]     wmask;
   logic [`IN_W-1:0] word0_view;

   // Fast lines
   logic [FAST_LINES-1:0] line_irq;
   logic [FAST_LINES-1:0] line_caught;
   logic [FAST_LINES-1:0] line_catch_mode;

   // Refresh spacing
   logic [15:0]     gap_cnt_reg;
   logic            gap_open_reg;

   // Filter length in ticks for a setting and word
   function automatic logic [10:0] limit_ticks(input logic [2:0] sel, input logic word1);
      logic [10:0] w1;
      w1 = `W1_TICKS_0;
      unique case (sel)
         3'h0: w1 = `W1_TICKS_0;
         3'h1: w1 = `W1_TICKS_1;
         3'h2: w1 = `W1_TICKS_2;
         3'h3: w1 = `W1_TICKS_3;
         3'h4: w1 = `W1_TICKS_4;
         3'h5: w1 = `W1_TICKS_5;
         3'h6: w1 = `W1_TICKS_6;
         3'h7: w1 = `W1_TICKS_7;
      endcase
      if (word1) begin
         return w1;
      end
      // First tick lands anywhere in its period; without one extra tick
      // word 000 could switch before the full constant has passed
      return 11'(`TICKS_PER_MS << sel) + `W0_EXTRA_TICKS;
   endfunction

   // Binary knob position to BCD, clamped to the top of the range
   function automatic word_t to_bcd(input logic [7:0] pos);
      logic [7:0] v;
      logic [3:0] hund;
      logic [7:0] rest;
      v    = (pos > `KNOB_MAX) ? `KNOB_MAX : pos;
      hund = 4'h0;
      rest = v;
      if (v >= 8'hC8) begin
         hund = 4'h2;
         rest = v - 8'hC8;
      end else if (v >= 8'h64) begin
         hund = 4'h1;
         rest = v - 8'h64;
      end
      return {4'h0, hund, 4'(rest / 8'h0A), 4'(rest % 8'h0A)};
   endfunction

   // Byte lane mask from select
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // two-stage synchronisers keep hardware delay far below 2 ms
   always_ff @(posedge core_clk) begin
      if (reset) begin
         in_meta_reg   <= '0;
         in_sync_reg   <= '0;
         knob_meta_reg <= 16'h0000;
         knob_sync_reg <= 16'h0000;
      end else begin
         in_meta_reg   <= in_pins;
         in_sync_reg   <= in_meta_reg;
         knob_meta_reg <= {knob_one_pos, knob_zero_pos};
         knob_sync_reg <= knob_meta_reg;
      end
   end

   // Time base tick for the filters
   assign tick = (tick_cnt_reg == 12'(`TICK_CYCLES - 1));

   always_ff @(posedge core_clk) begin
      if (reset || tick) begin
         tick_cnt_reg <= 12'h000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 12'h001;
      end
   end

   // selectable constant; word 000 length; shorter word 001
   always_ff @(posedge core_clk) begin
      if (reset) begin
         in_filt_reg <= '0;
         for (int i = 0; i < NIN; i++) begin
            flt_cnt_reg[i] <= 11'h000;
         end
      end else begin
         for (int i = 0; i < NIN; i++) begin
            if (in_sync_reg[i] == in_filt_reg[i]) begin
               flt_cnt_reg[i] <= 11'h000;
            end else if (flt_cnt_reg[i] >= limit_ticks(filt_sel_reg, i >= `IN_W)) begin
               in_filt_reg[i] <= in_sync_reg[i];
               flt_cnt_reg[i] <= 11'h000;
            end else if (tick) begin
               flt_cnt_reg[i] <= flt_cnt_reg[i] + 11'h001;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         knob_zero_reg <= 16'h0000;
         knob_one_reg  <= 16'h0000;
      end else begin
         knob_zero_reg <= to_bcd(knob_sync_reg[7:0]);
         knob_one_reg  <= to_bcd(knob_sync_reg[15:8]);
      end
   end

   // one line per fast terminal from bit 00003 upward
   genvar g;
   generate
      for (g = 0; g < FAST_LINES; g++) begin : gen_fast
         fast_line_if lnk ();
         // fast path bypasses the filter, answer in a few cycles
         assign lnk.pin         = in_sync_reg[`FAST_BIT0 + g];
         // the two-bit mode field gives each line a single role
         assign lnk.mode        = fast_mode_e'(mode_reg[2*g +: 2]);
         assign lnk.set_value   = set_val_reg[g];
         assign lnk.irq_ack     = irq_ack[g];
         assign lnk.clear_catch = rd && (wb_adr_i == `ADR_IN_W0);
         assign line_irq[g]     = lnk.irq;
         assign line_caught[g]  = lnk.caught;
         assign line_catch_mode[g] = (lnk.mode == FAST_CATCH);
         fast_line u_line (
            .core_clk (core_clk),
            .reset    (reset),
            .lnk      (lnk)
         );
      end
   endgenerate

   assign irq_req = line_irq;

   // fast bits read as plain inputs unless catching
   always_comb begin
      word0_view = in_filt_reg[`IN_W-1:0];
      for (int i = 0; i < FAST_LINES; i++) begin
         if (line_catch_mode[i]) begin
            word0_view[`FAST_BIT0 + i] = in_filt_reg[`FAST_BIT0 + i] | line_caught[i];
         end
      end
   end

   // Bus strobes: one answer per request, acknowledged in the next cycle
   assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr    = req & wb_we_i;
   assign rd    = req & ~wb_we_i;
   assign wmask = lane_mask(wb_sel_i);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // input words then output words, each from bit 00
   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (wb_adr_i)
         `ADR_IN_W0:  rd_data = 32'(word0_view);
         `ADR_IN_W1:  rd_data = 32'(in_filt_reg[NIN-1:`IN_W]);
         `ADR_OUT_W0: rd_data = 32'(out_w0_reg);
         `ADR_OUT_W1: rd_data = 32'(out_w1_reg);
         `ADR_FILT:   rd_data = 32'(filt_sel_reg);
         `ADR_MODE:   rd_data = 32'(mode_reg);
         `ADR_SETV0:  rd_data = 32'(set_val_reg[0]);
         `ADR_SETV1:  rd_data = 32'(set_val_reg[1]);
         `ADR_SETV2:  rd_data = 32'(set_val_reg[2]);
         `ADR_SETV3:  rd_data = 32'(set_val_reg[3]);
         `ADR_IRQ:    rd_data = 32'(line_irq);
         `ADR_STAT:   rd_data = 32'(fatal_refresh_error);
         {`IDX_KNOB0, 2'b00}: rd_data = 32'(knob_zero_reg);
         {`IDX_KNOB1, 2'b00}: rd_data = 32'(knob_one_reg);
         default:     rd_data = 32'h0000_0000;
      endcase
   end

   // Read data is held in a flop so it stays stable with ack
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd) begin
         wb_dat_o <= rd_data;
      end
   end

   // output words drive the output terminals
   always_ff @(posedge core_clk) begin
      if (reset) begin
         out_w0_reg <= '0;
         out_w1_reg <= '0;
      end else if (wr && wb_adr_i == `ADR_OUT_W0) begin
         out_w0_reg <= (out_w0_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end else if (wr && wb_adr_i == `ADR_OUT_W1) begin
         out_w1_reg <= (out_w1_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
   end

   assign out_pins = {out_w1_reg, out_w0_reg};

   always_ff @(posedge core_clk) begin
      if (reset) begin
         filt_sel_reg <= `FILT_SEL_RST;
      end else if (wr && wb_adr_i == `ADR_FILT && wb_sel_i[0]) begin
         filt_sel_reg <= wb_dat_i[2:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         mode_reg <= `MODE_RST;
      end else if (wr && wb_adr_i == `ADR_MODE && wb_sel_i[0]) begin
         mode_reg <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int i = 0; i < 4; i++) begin
            set_val_reg[i] <= `SETV_RST;
         end
      end else if (wr) begin
         for (int i = 0; i < 4; i++) begin
            if (wb_adr_i == `ADR_SETV0 + 12'(4 * i)) begin
               set_val_reg[i] <= (set_val_reg[i] & ~wmask[15:0])
                                 | (wb_dat_i[15:0] & wmask[15:0]);
            end
         end
      end
   end

   // refresh closer than the gap is a fatal error that stays until reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         gap_cnt_reg  <= 16'h0000;
         gap_open_reg <= 1'b1;
      end else if (immediate_io_refresh) begin
         gap_cnt_reg  <= 16'h0000;
         gap_open_reg <= 1'b0;
      end else if (!gap_open_reg) begin
         gap_cnt_reg  <= gap_cnt_reg + 16'h0001;
         gap_open_reg <= (gap_cnt_reg >= 16'(REFRESH_GAP_CYCLES - 2));
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         fatal_refresh_error <= 1'b0;
      end else if (immediate_io_refresh && !gap_open_reg) begin
         fatal_refresh_error <= 1'b1;
      end
   end

endmodule

// ---- testbench/input_cond_properties.sv ----
// Port checker for the input conditioning block
`timescale 1ns/1ps
module input_cond_properties #(
   parameter int FAST_LINES         = 4,
   parameter int REFRESH_GAP_CYCLES = 50
) (
   // Clock and reset
   input wire logic                  core_clk,
   input wire logic                  reset,
   // Bus
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_ack_o,
   // Field and scan engine
   input wire logic [23:0]           in_pins,
   input wire logic [31:0]           out_pins,
   input wire logic [FAST_LINES-1:0] irq_req,
   input wire logic [FAST_LINES-1:0] irq_ack,
   input wire logic                  immediate_io_refresh,
   input wire logic                  fatal_refresh_error
);
   int                    since;
   logic                  seen;
   logic                  close;
   logic                  near;
   logic [FAST_LINES-1:0] fast_pin;
   assign fast_pin = in_pins[FAST_LINES+2:3];
   // Two margins keep the one-cycle boundary of the gap out of the verdict
   always_ff @(posedge core_clk) begin
      if (reset) begin
         since <= 0;
         seen  <= 1'b0;
         close <= 1'b0;
         near  <= 1'b0;
      end else begin
         close <= immediate_io_refresh && seen && since < REFRESH_GAP_CYCLES - 2;
         near  <= immediate_io_refresh && seen && since <= REFRESH_GAP_CYCLES + 1;
         if (immediate_io_refresh)
            since <= 0;
         else if (since < REFRESH_GAP_CYCLES + 9)
            since <= since + 1;
         if (immediate_io_refresh)
            seen <= 1'b1;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_irq_held: assert property ((~irq_req & $past(irq_req) & ~$past(irq_ack)) == '0)
      else $error("interrupt request dropped without ack");
   a_irq_cause: assert property (
      (irq_req & ~$past(irq_req) & ~($past(fast_pin, 3) | $past(fast_pin, 4))) == '0)
      else $error("interrupt request without pin rise");
   a_fatal_sticky: assert property (fatal_refresh_error |=> fatal_refresh_error)
      else $error("fatal flag cleared without reset");
   a_fatal_set: assert property (close |-> ##[0:1] fatal_refresh_error)
      else $error("close refreshes not flagged");
   a_fatal_cause: assert property ($rose(fatal_refresh_error) |-> near || $past(near))
      else $error("fatal flag without close refreshes");
   a_out_reset: assert property (disable iff (1'b0) reset |=> out_pins == '0)
      else $error("outputs not cleared by reset");
endmodule

bind input_conditioning input_cond_properties #(
   .FAST_LINES(FAST_LINES),
   .REFRESH_GAP_CYCLES(REFRESH_GAP_CYCLES)
) chk (
   .core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .in_pins(in_pins), .out_pins(out_pins), .irq_req(irq_req),
   .irq_ack(irq_ack), .immediate_io_refresh(immediate_io_refresh),
   .fatal_refresh_error(fatal_refresh_error)
);

// ---- testbench/scan_engine_model.sv ----
// Scan engine model: serves interrupt requests and issues refreshes
`timescale 1ns/1ps
module scan_engine_model (
   // Clock and reset
   input  wire logic            core_clk,
   input  wire logic            reset,
   // Block side
   input  wire logic [3:0]      irq_req,
   output      logic [3:0]      irq_ack,
   output      logic            immediate_io_refresh,
   // Bench control
   input  wire logic            refresh_go,
   input  wire logic [7:0]      refresh_space,
   output      logic [3:0][7:0] ack_count
);
   logic [3:0][1:0] dly_reg;
   logic [7:0]      gap_reg;
   // one routine per request; a short wait mimics routine entry
   always_ff @(posedge core_clk) begin
      for (int g = 0; g < 4; g++) begin
         if (reset) begin
            irq_ack[g]   <= 1'b0;
            dly_reg[g]   <= 2'h0;
            ack_count[g] <= 8'h00;
         end else begin
            irq_ack[g] <= 1'b0;
            dly_reg[g] <= 2'h0;
            if (irq_req[g] && !irq_ack[g] && dly_reg[g] == 2'h2) begin
               irq_ack[g]   <= 1'b1;
               ack_count[g] <= ack_count[g] + 8'h01;
            end else if (irq_req[g] && !irq_ack[g]) begin
               dly_reg[g] <= dly_reg[g] + 2'h1;
            end
         end
      end
   end
   // refresh pairs at the spacing the bench asks, wide enough or too close
   always_ff @(posedge core_clk) begin
      if (reset) begin
         gap_reg              <= 8'h00;
         immediate_io_refresh <= 1'b0;
      end else begin
         immediate_io_refresh <= refresh_go || gap_reg == 8'h01;
         if (refresh_go)
            gap_reg <= refresh_space;
         else if (gap_reg != 8'h00)
            gap_reg <= gap_reg - 8'h01;
      end
   end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the input conditioning block
`timescale 1ns/1ps
`include "input_cond_consts.svh"
module testbench;
   logic core_clk, reset, cyc, stb, we, go, fatal;
   logic [11:0] adr;
   logic [3:0]  sel, irq_req, irq_ack;
   logic [31:0] dat_w, dat_r, out_pins, q;
   logic [23:0] in_pins;
   logic [7:0]  knob0, knob1, space;
   logic        ack, refresh;
   logic [3:0][7:0] ack_count;
   int err_count, samples_checked, cycles, n;

   input_conditioning #(.FAST_LINES(4), .REFRESH_GAP_CYCLES(50)) uut (
      .core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
      .wb_ack_o(ack), .in_pins(in_pins), .knob_zero_pos(knob0), .knob_one_pos(knob1),
      .out_pins(out_pins), .irq_req(irq_req), .irq_ack(irq_ack),
      .immediate_io_refresh(refresh), .fatal_refresh_error(fatal));
   scan_engine_model partner (
      .core_clk(core_clk), .reset(reset), .irq_req(irq_req), .irq_ack(irq_ack),
      .immediate_io_refresh(refresh), .refresh_go(go), .refresh_space(space),
      .ack_count(ack_count));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic close_out;
      $display("checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Holds the request until ack is sampled, then idles one cycle
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do begin
         @(posedge core_clk);
         k++;
      end while (ack !== 1'b1);
      q = dat_r;
      chk(32'(k), 32'h2);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask

   task automatic pulse(input logic [3:0] m, input int cnt);
      repeat (cnt) begin
         in_pins[6:3] <= m;
         repeat (8) @(posedge core_clk);
         in_pins[6:3] <= 4'h0;
         repeat (8) @(posedge core_clk);
      end
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         close_out();
      end
   end

   initial begin
      {reset, cyc, stb, we, go} = 5'h10;
      {adr, sel, dat_w, in_pins, space} = {12'h000, 4'hF, 32'h0, 24'h0, 8'h00};
      knob0 = 8'h7B;
      knob1 = 8'hFF;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      rd(`ADR_FILT, 32'h3);
      rd(`ADR_MODE, 32'h0);
      rd(`ADR_SETV1, 32'h0);
      rd({`IDX_KNOB0, 2'b00}, 32'h0123);
      rd({`IDX_KNOB1, 2'b00}, 32'h0200);
      bus(1'b1, 12'h3F0, 32'hFFFFFFFF);
      rd(12'h3F0, 32'h0);
      bus(1'b1, `ADR_OUT_W0, 32'h0000A5C3);
      bus(1'b1, `ADR_OUT_W1, 32'h00003C96);
      chk(out_pins, 32'h3C96A5C3);
      rd(`ADR_OUT_W1, 32'h00003C96);
      // Lines: 0 direct, 1 count, 2 catch, 3 count every pulse
      bus(1'b1, `ADR_SETV1, 32'h3);
      bus(1'b1, `ADR_MODE, 32'hB9);
      in_pins[3] <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (irq_req[0] !== 1'b1 && n < 9);
      chk(32'(n >= 3 && n <= 5), 32'h1);
      repeat (8) @(posedge core_clk);
      in_pins[3] <= 1'b0;
      repeat (8) @(posedge core_clk);
      pulse(4'hB, 6);
      chk(ack_count, {8'h06, 8'h00, 8'h02, 8'h07});
      in_pins[5] <= 1'b1;
      repeat (3) @(posedge core_clk);
      in_pins[5] <= 1'b0;
      repeat (8) @(posedge core_clk);
      rd(`ADR_IN_W0, 32'h20);
      rd(`ADR_IN_W0, 32'h0);
      chk(32'(ack_count[2]), 32'h0);
      // First pair is spaced wide enough, the second too close
      for (int i = 0; i < 2; i++) begin
         space <= (i == 0) ? 8'h3C : 8'h0A;
         go <= 1'b1;
         @(posedge core_clk);
         go <= 1'b0;
         repeat (80) @(posedge core_clk);
         rd(`ADR_STAT, (i == 0) ? 32'h0 : 32'h1);
      end
      bus(1'b1, `ADR_MODE, 32'h0);
      for (int s = 7; s >= 0; s--) begin
         bus(1'b1, `ADR_FILT, 32'(s));
         rd(`ADR_FILT, 32'(s));
      end
      // Fast bits sit in the pattern: with all modes off they are plain inputs
      in_pins <= 24'h3C5A78;
      repeat (2000) @(posedge core_clk);
      rd(`ADR_IN_W1, 32'h0);
      repeat (6000) @(posedge core_clk);
      rd(`ADR_IN_W1, 32'h3C5);
      repeat (16000) @(posedge core_clk);
      rd(`ADR_IN_W0, 32'h0);
      repeat (13000) @(posedge core_clk);
      rd(`ADR_IN_W0, 32'hA78);
      chk(ack_count, {8'h06, 8'h00, 8'h02, 8'h07});
      chk({31'h0, fatal}, 32'h1);
      close_out();
   end
endmodule
